// File: ldp_pkg.sv
package ldp_pkg;
  // Geometry
  localparam int CH_NUM        = 16;
  localparam int TMR_NUM       = 4;
  localparam int CNT_W         = 20;
  localparam int STEP_W        = 10;
  localparam int ADDR_W        = 12;
  // Clocks: the timebase counts on clk_sys or on the divided oscillator tick
  localparam int SYS_CLK_HZ    = 40_000_000;
  localparam int OSC_CLK_HZ    = 8_000_000;
  localparam int OSC_DIV       = SYS_CLK_HZ / OSC_CLK_HZ;
  localparam int OSC_DIV_W     = 3;
  localparam int OSC_CH_FIRST  = 8;
  localparam int OSC_TMR_FIRST = 2;
  // Address map
  localparam logic [3:0] CH_PAGE  = 4'h0;
  localparam logic [7:0] TMR_PAGE = 8'h10;
  localparam logic [3:0] OFS_CONF = 4'h0;
  localparam logic [3:0] OFS_DUTY = 4'h4;
  localparam logic [3:0] OFS_RAMP = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  localparam int CH_SEL_LSB   = 4;
  localparam int CH_SEL_MSB   = 7;
  localparam int OFS_MSB      = 3;
  localparam int TMR_SEL_LSB  = 2;
  localparam int TMR_SEL_MSB  = 3;
  localparam int CH_PAGE_LSB  = 8;
  localparam int TMR_PAGE_LSB = 4;
  // Channel configuration fields
  localparam int CONF_TSEL_LSB = 0;
  localparam int CONF_EN_BIT   = 2;
  localparam int CONF_W        = 3;
  // Ramp fields
  localparam int RAMP_STEP_LSB = 0;
  localparam int RAMP_NUM_LSB  = 10;
  localparam int RAMP_UP_BIT   = 20;
  localparam int RAMP_W        = 21;
  localparam int RAMP_GO_BIT   = 31;
  // Timer fields
  localparam int TMR_SRC_BIT   = 20;
  localparam int TMR_RUN_BIT   = 21;
  localparam int TMR_W         = 22;
  // Status fields
  localparam int STAT_BUSY_BIT = 20;
  localparam int STAT_OUT_BIT  = 21;
  // Reset values and answers
  localparam logic [CONF_W-1:0] CONF_RST = 3'h0;
  localparam logic [RAMP_W-1:0] RAMP_RST = 21'h0;
  localparam logic [TMR_W-1:0]  TMR_RST  = 22'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ldp_pkg

// File: ldp_channel.sv
`timescale 1ns/100ps
module ldp_channel
  import ldp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Timebase
  input  wire logic              enable,
  input  wire logic [CNT_W-1:0]  timerCnt,
  input  wire logic              timerWrap,
  // Software commands
  input  wire logic              dutyWr,
  input  wire logic [CNT_W-1:0]  dutyVal,
  input  wire logic              rampGo,
  input  wire logic [STEP_W-1:0] rampStep,
  input  wire logic [STEP_W-1:0] rampNum,
  input  wire logic              rampUp,
  // State
  output logic                   pwmOut,
  output logic [CNT_W-1:0]       dutyNow,
  output logic                   rampBusy
);
  logic              pwm_r;
  logic [CNT_W-1:0]  duty_r;
  logic              busy_r;
  logic [STEP_W-1:0] left_r;
  logic [STEP_W-1:0] step_r;
  logic              up_r;

  // Saturate so a long ramp parks at full or zero instead of wrapping around
  wire  [CNT_W:0]    dutySum  = {1'b0, duty_r} + {{(CNT_W-STEP_W+1){1'b0}}, step_r};
  wire               sumOvf   = dutySum[CNT_W];
  wire               subUnder = duty_r < {{(CNT_W-STEP_W){1'b0}}, step_r};
  wire  [CNT_W-1:0]  dutyUp   = sumOvf ? {CNT_W{1'b1}} : dutySum[CNT_W-1:0];
  wire  [CNT_W-1:0]  dutyDown = subUnder ? {CNT_W{1'b0}}
                              : duty_r - {{(CNT_W-STEP_W){1'b0}}, step_r};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_r  <= 1'b0;
      duty_r <= '0;
      busy_r <= 1'b0;
      left_r <= '0;
      step_r <= '0;
      up_r   <= 1'b0;
    end else begin
      pwm_r <= enable & (timerCnt < duty_r);
      if (dutyWr) begin
        duty_r <= dutyVal;
        busy_r <= 1'b0;
      end else if (rampGo) begin
        busy_r <= rampNum != '0;
        left_r <= rampNum;
        step_r <= rampStep;
        up_r   <= rampUp;
      end else if (busy_r & timerWrap) begin
        duty_r <= up_r ? dutyUp : dutyDown;
        left_r <= left_r - 1'b1;
        busy_r <= left_r != {{(STEP_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign pwmOut   = pwm_r;
  assign dutyNow  = duty_r;
  assign rampBusy = busy_r;
endmodule : ldp_channel

// File: ldp_top.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module ldp_top
  import ldp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // LED outputs
  output logic [CH_NUM-1:0]      ledOut
);
  logic                 awReady_r;
  logic [ADDR_W-1:0]    awAddr_r;
  logic                 wReady_r;
  logic [31:0]          wData_r;
  logic [3:0]           wStrb_r;
  logic                 bValid_r;
  logic [1:0]           bResp_r;
  logic                 arReady_r;
  logic                 rValid_r;
  logic [31:0]          rData_r;
  logic [1:0]           rResp_r;
  logic [CONF_W-1:0]    confReg_r [CH_NUM];
  logic [RAMP_W-1:0]    rampReg_r [CH_NUM];
  logic [TMR_W-1:0]     tmrReg_r  [TMR_NUM];
  logic [CNT_W-1:0]     tmrCnt_r  [TMR_NUM];
  logic [TMR_NUM-1:0]   tmrWrap;
  logic [OSC_DIV_W-1:0] oscDiv_r;
  logic                 oscTick_r;
  logic [CNT_W-1:0]     dutyNow   [CH_NUM];
  logic [CH_NUM-1:0]    rampBusy;
  logic [CH_NUM-1:0]    pwmOut;

  // Write side: address and data are held separately, the write fires once both are in
  wire        awTake  = s_axi_awvalid & awReady_r;
  wire        wTake   = s_axi_wvalid & wReady_r;
  wire        doWrite = ~awReady_r & ~wReady_r & ~bValid_r;
  wire [3:0]  wrCh    = awAddr_r[CH_SEL_MSB:CH_SEL_LSB];
  wire [3:0]  wrOfs   = awAddr_r[OFS_MSB:0];
  wire [1:0]  wrTmr   = awAddr_r[TMR_SEL_MSB:TMR_SEL_LSB];
  wire        wrIsCh  = awAddr_r[ADDR_W-1:CH_PAGE_LSB] == CH_PAGE;
  wire        wrIsTmr = awAddr_r[ADDR_W-1:TMR_PAGE_LSB] == TMR_PAGE;
  wire        wrHit   = wrIsCh | wrIsTmr;
  wire        wrConf  = doWrite & wrIsCh & (wrOfs == OFS_CONF);
  wire        wrDuty  = doWrite & wrIsCh & (wrOfs == OFS_DUTY);
  wire        wrRamp  = doWrite & wrIsCh & (wrOfs == OFS_RAMP);
  wire        wrTimer = doWrite & wrIsTmr;
  wire [31:0] wrMask  = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

  function automatic logic [31:0] mergeWord(input logic [31:0] old);
    mergeWord = (old & ~wrMask) | (wData_r & wrMask);
  endfunction : mergeWord

  wire [31:0] confMerged = mergeWord(32'(confReg_r[wrCh]));
  wire [31:0] dutyMerged = mergeWord(32'(dutyNow[wrCh]));
  wire [31:0] rampMerged = mergeWord(32'(rampReg_r[wrCh]));
  wire [31:0] tmrMerged  = mergeWord(32'(tmrReg_r[wrTmr]));

  // Read side decode
  wire        arTake  = s_axi_arvalid & arReady_r;
  wire [3:0]  rdCh    = s_axi_araddr[CH_SEL_MSB:CH_SEL_LSB];
  wire [3:0]  rdOfs   = s_axi_araddr[OFS_MSB:0];
  wire [1:0]  rdTmr   = s_axi_araddr[TMR_SEL_MSB:TMR_SEL_LSB];
  wire        rdIsCh  = s_axi_araddr[ADDR_W-1:CH_PAGE_LSB] == CH_PAGE;
  wire        rdIsTmr = s_axi_araddr[ADDR_W-1:TMR_PAGE_LSB] == TMR_PAGE;
  wire [31:0] rdStat  = 32'({pwmOut[rdCh], rampBusy[rdCh], dutyNow[rdCh]});
  wire [31:0] rdChWord = (rdOfs == OFS_CONF) ? 32'(confReg_r[rdCh])
                       : (rdOfs == OFS_DUTY) ? 32'(dutyNow[rdCh])
                       : (rdOfs == OFS_RAMP) ? 32'(rampReg_r[rdCh])
                       : rdStat;
  wire [31:0] rdWord  = rdIsCh ? rdChWord : rdIsTmr ? 32'(tmrReg_r[rdTmr]) : 32'h0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      awReady_r <= 1'b1;
      awAddr_r  <= '0;
      wReady_r  <= 1'b1;
      wData_r   <= 32'h0;
      wStrb_r   <= 4'h0;
      bValid_r  <= 1'b0;
      bResp_r   <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awReady_r <= 1'b0;
        awAddr_r  <= s_axi_awaddr;
      end else if (doWrite) begin
        awReady_r <= 1'b1;
      end
      if (wTake) begin
        wReady_r <= 1'b0;
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
      end else if (doWrite) begin
        wReady_r <= 1'b1;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rData_r   <= 32'h0;
      rResp_r   <= RESP_OKAY;
    end else if (arTake) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b1;
      rData_r   <= rdWord;
      rResp_r   <= (rdIsCh | rdIsTmr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_r & s_axi_rready) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
    end
  end

  // Oscillator tick: clk_sys divided down to the 8 MHz rate
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oscDiv_r  <= '0;
      oscTick_r <= 1'b0;
    end else begin
      oscTick_r <= oscDiv_r == OSC_DIV_W'(OSC_DIV - 1);
      oscDiv_r  <= (oscDiv_r == OSC_DIV_W'(OSC_DIV - 1)) ? '0 : oscDiv_r + 1'b1;
    end
  end

  genvar t;
  generate
    for (t = 0; t < TMR_NUM; t++) begin : gTmr
      wire [CNT_W-1:0] range  = tmrReg_r[t][CNT_W-1:0];
      wire             run    = tmrReg_r[t][TMR_RUN_BIT];
      // Only the oscillator-capable timers honour the source bit
      wire             useOsc = (t >= OSC_TMR_FIRST) & tmrReg_r[t][TMR_SRC_BIT];
      wire             tick   = run & (useOsc ? oscTick_r : 1'b1);
      assign tmrWrap[t] = tick & (tmrCnt_r[t] >= range);

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          tmrReg_r[t] <= TMR_RST;
          tmrCnt_r[t] <= '0;
        end else begin
          if (wrTimer && wrTmr == 2'(t)) begin
            tmrReg_r[t] <= tmrMerged[TMR_W-1:0];
          end
          if (!run) begin
            tmrCnt_r[t] <= '0;
          end else if (tick) begin
            tmrCnt_r[t] <= tmrWrap[t] ? '0 : tmrCnt_r[t] + 1'b1;
          end
        end
      end
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : gCh
      wire       hit  = wrCh == 4'(c);
      // Low channels cannot reach the oscillator-capable timers
      wire [1:0] tsel = {(c >= OSC_CH_FIRST) & confReg_r[c][CONF_TSEL_LSB+1],
                         confReg_r[c][CONF_TSEL_LSB]};

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          confReg_r[c] <= CONF_RST;
          rampReg_r[c] <= RAMP_RST;
        end else begin
          if (wrConf & hit) begin
            confReg_r[c] <= confMerged[CONF_W-1:0];
          end
          if (wrRamp & hit) begin
            rampReg_r[c] <= rampMerged[RAMP_W-1:0];
          end
        end
      end

      ldp_channel uChan (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .enable    (confReg_r[c][CONF_EN_BIT]),
        .timerCnt  (tmrCnt_r[tsel]),
        .timerWrap (tmrWrap[tsel]),
        .dutyWr    (wrDuty & hit),
        .dutyVal   (dutyMerged[CNT_W-1:0]),
        .rampGo    (wrRamp & hit & rampMerged[RAMP_GO_BIT]),
        .rampStep  (rampMerged[RAMP_STEP_LSB +: STEP_W]),
        .rampNum   (rampMerged[RAMP_NUM_LSB +: STEP_W]),
        .rampUp    (rampMerged[RAMP_UP_BIT]),
        .pwmOut    (pwmOut[c]),
        .dutyNow   (dutyNow[c]),
        .rampBusy  (rampBusy[c])
      );
    end
  endgenerate

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign ledOut        = pwmOut;
endmodule : ldp_top

// File: ldp_assertions.sv
`timescale 1ns/100ps
module ldp_assertions
  import ldp_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake  = s_axi_wvalid && s_axi_wready;
  a_write_answer: assert property ((awTake && wTake) |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two edges after handshake");
  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  a_aw_block: assert property (awTake |=> !s_axi_awready)
    else $error("address ready while write pending");
  a_resp_after: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write answered before address and data were held");
  a_err_data: assert property ((s_axi_rvalid && s_axi_rresp == RESP_SLVERR) |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  c_write: cover property (awTake && wTake);
  c_refuse: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_slow_answer: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : ldp_assertions

// File: ldp_led_load.sv
`timescale 1ns/100ps
module ldp_led_load
  import ldp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // LED pins and probe control
  input  wire logic [CH_NUM-1:0] ledOut,
  input  wire logic [3:0]        chSel,
  input  wire logic              cntClr,
  output logic [15:0]            highCnt_r
);
  // An LED cannot talk back, so the load only tallies lit cycles
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) highCnt_r <= 16'h0;
    else if (cntClr) highCnt_r <= 16'h0;
    else if (ledOut[chSel]) highCnt_r <= highCnt_r + 16'h1;
  end
endmodule : ldp_led_load

// File: ldp_top_test.sv
`timescale 1ns/100ps
module ldp_top_test;
  import ldp_pkg::*;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata, rd;
  logic [CH_NUM-1:0] ledOut;
  logic [3:0]        chSel = 4'h0;
  logic              cntClr = 1'b0;
  // Late response ready keeps the answer standing for a cycle
  logic              slowAck = 1'b0;
  logic [15:0]       highCnt;
  int                err_count = 0, checked = 0, cyc = 0;
  ldp_top DUT (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ledOut);
  ldp_led_load LOAD (.clk_sys, .sys_rst, .ledOut, .chSel, .cntClr, .highCnt_r(highCnt));
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  task close_out;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task check_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : check_resp
  task check_count(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask : check_count
  task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slowAck;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      ad = ad | (s_axi_awvalid & s_axi_awready);
      wd = wd | (s_axi_wvalid & s_axi_wready);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(posedge clk_sys);
      if (!s_axi_bready && s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    check_resp(s_axi_bresp, er);
  endtask : axi_write
  task axi_read(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slowAck;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (!s_axi_rready && s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check_resp(s_axi_rresp, er);
  endtask : axi_read
  task measure(input logic [3:0] ch, input int n, input logic [15:0] exp);
    @(posedge clk_sys);
    chSel <= ch;
    cntClr <= 1'b1;
    @(posedge clk_sys);
    cntClr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    check_count(highCnt, exp);
  endtask : measure
  task t_reset;
    for (int i = 0; i < 4; i++) begin
      axi_read(12'(12'hf0 + i * 4), RESP_OKAY, rd);
      check_val(rd, 32'h0);
    end
    axi_read(12'h10c, RESP_OKAY, rd);
    check_val(rd, 32'h0);
    axi_read(12'h110, RESP_SLVERR, rd);
    axi_write(12'h200, 32'h1, RESP_SLVERR);
    axi_write(12'h02c, 32'h1, RESP_OKAY);
    axi_write(12'h024, 32'h1fffff, RESP_OKAY);
    axi_read(12'h024, RESP_OKAY, rd);
    check_val(rd, 32'hfffff);
  endtask : t_reset
  task t_pwm;
    logic [15:0] d;
    axi_write(12'h100, 32'h200009, RESP_OKAY);
    axi_write(12'h104, 32'h200004, RESP_OKAY);
    for (int ch = 0; ch < CH_NUM; ch++) begin
      d = 16'(ch % 4 + 1);
      axi_write(12'(ch * 16), 32'(4 + ch % 2), RESP_OKAY);
      axi_write(12'(ch * 16 + 4), 32'(d), RESP_OKAY);
      measure(4'(ch), 100, (ch % 2) ? 16'(20 * d) : 16'(10 * d));
    end
  endtask : t_pwm
  task t_osc;
    axi_write(12'h108, 32'h300004, RESP_OKAY);
    axi_write(12'h080, 32'h6, RESP_OKAY);
    axi_write(12'h084, 32'h2, RESP_OKAY);
    measure(4'h8, 250, 16'd100);
    // Low channels cannot reach the oscillator timers, so select 2 falls back to timer 0
    axi_write(12'h000, 32'h6, RESP_OKAY);
    measure(4'h0, 100, 16'd10);
  endtask : t_osc
  task wait_idle;
    repeat (40) begin
      axi_read(12'h01c, RESP_OKAY, rd);
      if (rd[20] == 1'b0) break;
    end
  endtask : wait_idle
  task t_ramp;
    axi_write(12'h014, 32'h10, RESP_OKAY);
    axi_write(12'h018, 32'h80101003, RESP_OKAY);
    wait_idle();
    check_val({12'h0, rd[19:0]}, 32'h1c);
    axi_write(12'h018, 32'h80001410, RESP_OKAY);
    wait_idle();
    check_val({12'h0, rd[19:0]}, 32'h0);
    axi_write(12'h018, 32'h801ffc01, RESP_OKAY);
    axi_read(12'h01c, RESP_OKAY, rd);
    check_val({31'h0, rd[20]}, 32'h1);
    axi_write(12'h014, 32'h5, RESP_OKAY);
    axi_read(12'h01c, RESP_OKAY, rd);
    check_val(rd, 32'h200005);
  endtask : t_ramp
  // Byte strobes and a late ready; channel 15 still holds duty 4 here
  task t_strobe;
    slowAck = 1'b1;
    s_axi_wstrb <= 4'h2;
    axi_write(12'h0f4, 32'h12345678, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_read(12'h0f4, RESP_OKAY, rd);
    check_val(rd, 32'h5604);
    axi_read(12'h110, RESP_SLVERR, rd);
    check_val(rd, 32'h0);
    axi_write(12'h300, 32'h1, RESP_SLVERR);
    slowAck = 1'b0;
  endtask : t_strobe
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_pwm();
    t_osc();
    t_ramp();
    t_strobe();
    close_out();
  end
endmodule : ldp_top_test
bind ldp_top ldp_assertions CHK (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
